/* core/tis_device_end.sv */
// Overview of operation
// [RL1] flags update regardless of enable bits
// [RL2] irq high while any enabled flag set
// [RL3] flags may change in different cycles
// [RL4] bit 7 set once oscillator settled
// [RL5] bit 6 follows battery, off without manager
// [RL6] bit 5 set at 15 bytes or fewer
// [RL7] bit 4 set at eight bytes or fewer
// [RL8] bit 3 set while buffer empty
// [RL9] bit 2 set on buffer underflow
// [RL10] bit 2 set on write into full buffer
// [RL11] bit 2 held until buffer clear command
// [RL12] no transaction mode: done after checksum
// [RL13] transaction mode: done after whole transaction
// [RL14] status read clears done and fail
// [RL15] host rereads when done without fail; the host only does so for status commands with the transaction bit set
// [RL16] host never rereads after done with fail
// [RL17] done may stay clear on failure
// [RL18] outcome may appear in receive flags
// [RL19] bit 0 set on acknowledgement timeout in transaction mode
// [RL20] writing one to clear empties buffer
// [RL21] host sets done and fail enables together
// [RL22] fill flags from zero-to-sixteen counter
`timescale 1ns/100ps
`include "tis_consts.svh"

module tis_device_end
  import tis_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  tis_link_if.device link,
  input wire logic osc_settled_i,
  input wire logic battery_below_i,
  input wire logic xact_mode_i,
  input wire logic tx_byte_req_i,
  input wire logic bytes_pending_i,
  input wire logic crc_sent_i,
  input wire logic xact_done_i,
  input wire logic ack_timeout_i,
  output tis_byte_type tx_data_o,
  output logic tx_data_strobe_o,
  output logic tx_go_o,
  output logic power_manager_en_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic addr_hit(input tis_byte_type a, input tis_byte_type ofs);
    addr_hit = (a == ofs);
  endfunction
  // ****************************************
  // declarations
  // ****************************************
  logic osc_meta_ff, osc_sync_ff, bat_meta_ff, bat_sync_ff;
  logic ack_ff, irq_ff, go_ff, buferr_ff, done_ff, fail_ff, strobe_ff;
  logic [5:0] ctrl_en_ff;
  tis_byte_type rdata_ff, pwr_ff;
  logic nxt_buferr, nxt_done, nxt_fail, nxt_irq;
  logic access, rd, wr, status_rd, ctrl_wr, pwr_wr, buf_wr, clear_cmd;
  logic pop, end_of_packet, lowbat_flag, full, empty;
  logic [4:0] count;
  tis_byte_type fifo_data, status_vec, enable_vec;
  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      bat_meta_ff <= 1'b0;
      bat_sync_ff <= 1'b0;
    end
    else
    begin
      osc_meta_ff <= osc_settled_i;
      osc_sync_ff <= osc_meta_ff;
      bat_meta_ff <= battery_below_i;
      bat_sync_ff <= bat_meta_ff;
    end
  end
  // ****************************************
  // link decode
  // ****************************************
  // ack_ff blocks a second action while host still holds req
  assign access = link.req & ~ack_ff;
  assign rd = access & ~link.we;
  assign wr = access & link.we;
  assign status_rd = rd & addr_hit(link.addr, `TIS_OFS_TX_STATUS);
  assign ctrl_wr = wr & addr_hit(link.addr, `TIS_OFS_TX_CTRL);
  assign pwr_wr = wr & addr_hit(link.addr, `TIS_OFS_POWER_CTRL);
  assign buf_wr = wr & addr_hit(link.addr, `TIS_OFS_TX_BUFFER);
  assign clear_cmd = ctrl_wr & link.wdata[`TIS_BIT_CLR]; // see [RL20]
  // ****************************************
  // transmit buffer
  // ****************************************
  // clear wins over a same-cycle pop, so no stale strobe goes out
  assign pop = tx_byte_req_i & ~empty & ~clear_cmd;
  tis_tx_fifo u_fifo
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .push_i(buf_wr),
    .data_i(link.wdata),
    .pop_i(pop),
    .clear_i(clear_cmd), // see [RL20]
    .data_o(fifo_data),
    .count_o(count),
    .full_o(full),
    .empty_o(empty)
  );
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      strobe_ff <= 1'b0;
    end
    else
    begin
      strobe_ff <= pop;
    end
  end
  // ****************************************
  // status vector
  // ****************************************
  assign lowbat_flag = pwr_ff[`TIS_BIT_PM_EN] & bat_sync_ff; // see [RL5]
  always_comb
  begin
    status_vec = `TIS_BYTE_ZERO;
    status_vec[`TIS_BIT_OSC] = osc_sync_ff; // see [RL4]
    status_vec[`TIS_BIT_LOWBAT] = lowbat_flag; // see [RL5]
    status_vec[`TIS_BIT_NOT_FULL] = (count <= `TIS_NOT_FULL_MAX); // see [RL6]
    status_vec[`TIS_BIT_HALF] = (count <= `TIS_HALF_MAX); // see [RL7]
    status_vec[`TIS_BIT_EMPTY] = (count == `TIS_CNT_ZERO); // see [RL8]
    status_vec[`TIS_BIT_BUFERR] = buferr_ff;
    status_vec[`TIS_BIT_DONE] = done_ff;
    status_vec[`TIS_BIT_FAIL] = fail_ff;
  end
  // ****************************************
  // sticky flags, set wins over clear
  // ****************************************
  // flags ignore the enables so polling works; see [RL1]
  assign end_of_packet = xact_mode_i ? xact_done_i : crc_sent_i; // see [RL12] see [RL13]
  always_comb
  begin
    nxt_buferr = (tx_byte_req_i & empty & bytes_pending_i) // see [RL9]
      | (buf_wr & full) // see [RL10]
      | (buferr_ff & ~clear_cmd); // see [RL11]
    nxt_done = end_of_packet | (done_ff & ~status_rd); // see [RL14]
    nxt_fail = (xact_mode_i & ack_timeout_i) | (fail_ff & ~status_rd); // see [RL19] see [RL14]
  end
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      buferr_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
    end
    else
    begin
      buferr_ff <= nxt_buferr;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
    end
  end
  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_en_ff <= `TIS_CTRL_EN_RESET;
      pwr_ff <= `TIS_PWR_RESET;
    end
    else
    begin
      if (ctrl_wr)
      begin
        ctrl_en_ff <= link.wdata[5:0];
      end
      if (pwr_wr)
      begin
        pwr_ff <= link.wdata;
      end
    end
  end
  // a new start written at the end edge wins, so no packet is lost
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      go_ff <= 1'b0;
    end
    else if (ctrl_wr && link.wdata[`TIS_BIT_GO])
    begin
      go_ff <= 1'b1;
    end
    else if (end_of_packet)
    begin
      go_ff <= 1'b0;
    end
  end
  // ****************************************
  // interrupt output
  // ****************************************
  // one cycle behind the flags, as the output must come from a flop
  assign enable_vec = {pwr_ff[`TIS_BIT_OSC_EN], pwr_ff[`TIS_BIT_LOWBAT_EN], ctrl_en_ff};
  assign nxt_irq = |(status_vec & enable_vec); // see [RL2]
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
    end
  end
  // ****************************************
  // link answer
  // ****************************************
  // status snapshot is taken at the same edge that clears done and fail
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= `TIS_BYTE_ZERO;
    end
    else
    begin
      ack_ff <= access;
      if (rd)
      begin
        if (addr_hit(link.addr, `TIS_OFS_TX_STATUS))
        begin
          rdata_ff <= status_vec;
        end
        else if (addr_hit(link.addr, `TIS_OFS_TX_CTRL))
        begin
          rdata_ff <= {go_ff, 1'b0, ctrl_en_ff};
        end
        else if (addr_hit(link.addr, `TIS_OFS_POWER_CTRL))
        begin
          rdata_ff <= pwr_ff;
        end
        else
        begin
          rdata_ff <= `TIS_BYTE_ZERO;
        end
      end
    end
  end
  assign link.ack = ack_ff;
  assign link.rdata = rdata_ff;
  assign link.irq = irq_ff;
  assign tx_data_o = fifo_data;
  assign tx_data_strobe_o = strobe_ff;
  assign tx_go_o = go_ff;
  assign power_manager_en_o = pwr_ff[`TIS_BIT_PM_EN];
endmodule

/* common/tis_consts.svh */
`ifndef TIS_CONSTS_SVH
`define TIS_CONSTS_SVH

// ****************************************
// register offsets on the link
// ****************************************
`define TIS_OFS_TX_CTRL 8'h02
`define TIS_OFS_TX_STATUS 8'h04
`define TIS_OFS_TX_BUFFER 8'h20
`define TIS_OFS_POWER_CTRL 8'h26

// ****************************************
// status bit positions
// ****************************************
`define TIS_BIT_OSC 7
`define TIS_BIT_LOWBAT 6
`define TIS_BIT_NOT_FULL 5
`define TIS_BIT_HALF 4
`define TIS_BIT_EMPTY 3
`define TIS_BIT_BUFERR 2
`define TIS_BIT_DONE 1
`define TIS_BIT_FAIL 0

// ****************************************
// control bit positions and reset values
// ****************************************
`define TIS_BIT_GO 7
`define TIS_BIT_CLR 6
`define TIS_CTRL_EN_RESET 6'h03
`define TIS_BIT_PM_EN 7
`define TIS_BIT_OSC_EN 1
`define TIS_BIT_LOWBAT_EN 0
`define TIS_PWR_RESET 8'h00
`define TIS_BYTE_ZERO 8'h00

// ****************************************
// transmit buffer
// ****************************************
`define TIS_FIFO_DEPTH 16
`define TIS_FIFO_FULL 5'h10
`define TIS_NOT_FULL_MAX 5'h0F
`define TIS_HALF_MAX 5'h08
`define TIS_CNT_ZERO 5'h00
`define TIS_CNT_ONE 5'h01
`define TIS_PTR_ZERO 4'h0
`define TIS_PTR_ONE 4'h1

// ****************************************
// host wishbone map
// ****************************************
`define TIS_WB_CMD 4'h0
`define TIS_WB_RESULT 4'h4
`define TIS_CMD_WE 16
`define TIS_CMD_STAT 17
`define TIS_CMD_XACT 18
`define TIS_RES_BUSY 16
`define TIS_RES_IRQ 17
`define TIS_RES_SECOND 18
`define TIS_WORD_ZERO 32'h00000000

`endif

/* common/tis_pkg.sv */
package tis_pkg;

  typedef logic [7:0] tis_byte_type;

  typedef enum logic [1:0]
  {
    tis_idle = 2'b00,
    tis_wait = 2'b01,
    tis_gap = 2'b10
  } tis_host_state_type;

endpackage

/* common/tis_link_if.sv */
`timescale 1ns/100ps

interface tis_link_if;
  import tis_pkg::*;

  logic req;
  logic we;
  tis_byte_type addr;
  tis_byte_type wdata;
  tis_byte_type rdata;
  logic ack;
  logic irq;

  modport device
  (
    input req,
    input we,
    input addr,
    input wdata,
    output rdata,
    output ack,
    output irq
  );

  modport host
  (
    output req,
    output we,
    output addr,
    output wdata,
    input rdata,
    input ack,
    input irq
  );
endinterface

/* core/tis_tx_fifo.sv */
`timescale 1ns/100ps
`include "tis_consts.svh"

module tis_tx_fifo
  import tis_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic push_i,
  input wire tis_byte_type data_i,
  input wire logic pop_i,
  input wire logic clear_i,
  output tis_byte_type data_o,
  output logic [4:0] count_o,
  output logic full_o,
  output logic empty_o
);

  tis_byte_type mem_ff [0:`TIS_FIFO_DEPTH-1];
  logic [3:0] wr_ptr_ff;
  logic [3:0] rd_ptr_ff;
  logic [4:0] count_ff;
  tis_byte_type data_ff;
  logic do_push;
  logic do_pop;

  assign full_o = (count_ff == `TIS_FIFO_FULL);
  assign empty_o = (count_ff == `TIS_CNT_ZERO);
  // clear has priority so a stale push cannot survive it
  assign do_push = push_i & ~full_o & ~clear_i;
  assign do_pop = pop_i & ~empty_o & ~clear_i;
  assign count_o = count_ff;
  assign data_o = data_ff;

  // ****************************************
  // storage, no reset needed on data
  // ****************************************
  always_ff @(posedge clock_i)
  begin
    if (do_push)
    begin
      mem_ff[wr_ptr_ff] <= data_i;
    end
  end

  // ****************************************
  // pointers and fill counter
  // ****************************************
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_ff <= `TIS_PTR_ZERO;
      rd_ptr_ff <= `TIS_PTR_ZERO;
      count_ff <= `TIS_CNT_ZERO;
    end
    else if (clear_i)
    begin
      wr_ptr_ff <= `TIS_PTR_ZERO;
      rd_ptr_ff <= `TIS_PTR_ZERO;
      count_ff <= `TIS_CNT_ZERO;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_ff <= wr_ptr_ff + `TIS_PTR_ONE;
      end
      if (do_pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + `TIS_PTR_ONE;
      end
      if (do_push && !do_pop)
      begin
        count_ff <= count_ff + `TIS_CNT_ONE; // see [RL22]
      end
      else if (do_pop && !do_push)
      begin
        count_ff <= count_ff - `TIS_CNT_ONE; // see [RL22]
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_ff <= `TIS_BYTE_ZERO;
    end
    else if (do_pop)
    begin
      data_ff <= mem_ff[rd_ptr_ff];
    end
  end

endmodule

/* core/tis_host_end.sv */
`timescale 1ns/100ps
`include "tis_consts.svh"

module tis_host_end
  import tis_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  tis_link_if.host link
);

  tis_host_state_type state_ff;
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;
  logic req_ff;
  logic we_ff;
  tis_byte_type addr_ff;
  tis_byte_type wdata_ff;
  tis_byte_type rdata_ff;
  tis_byte_type final_ff;
  logic stat_op_ff;
  logic xact_ff;
  logic second_ff;
  logic wb_access;
  logic start;
  logic need_second;
  tis_byte_type cmd_wdata;

  // ****************************************
  // wishbone slave
  // ****************************************
  assign wb_access = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  // command word writes that leave out any of byte lanes 0 to 2 are ignored
  assign start = wb_access & wb_we_i & (wb_adr_i == `TIS_WB_CMD) & (&wb_sel_i[2:0])
    & (state_ff == tis_idle);

  always_comb
  begin
    cmd_wdata = wb_dat_i[7:0];
    if (wb_dat_i[15:8] == `TIS_OFS_TX_CTRL)
    begin
      cmd_wdata[`TIS_BIT_FAIL] = wb_dat_i[`TIS_BIT_DONE]; // see [RL21]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= `TIS_WORD_ZERO;
    end
    else
    begin
      wb_ack_ff <= wb_access;
      if (wb_access && !wb_we_i)
      begin
        wb_dat_ff <= `TIS_WORD_ZERO;
        if (wb_adr_i == `TIS_WB_CMD)
        begin
          wb_dat_ff <= {13'h0000, xact_ff, stat_op_ff, we_ff, addr_ff, wdata_ff};
        end
        else if (wb_adr_i == `TIS_WB_RESULT)
        begin
          // raw irq kept visible; done alone may never come; see [RL17] see [RL18]
          wb_dat_ff <= {13'h0000, second_ff, link.irq, (state_ff != tis_idle),
                        final_ff, rdata_ff};
        end
      end
    end
  end

  // ****************************************
  // link sequencer
  // ****************************************
  // reread only when the first shows done without fail; see [RL15] see [RL16] see [RL3]
  assign need_second = stat_op_ff & xact_ff & ~second_ff
    & link.rdata[`TIS_BIT_DONE] & ~link.rdata[`TIS_BIT_FAIL];

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff <= tis_idle;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= `TIS_BYTE_ZERO;
      wdata_ff <= `TIS_BYTE_ZERO;
      rdata_ff <= `TIS_BYTE_ZERO;
      final_ff <= `TIS_BYTE_ZERO;
      stat_op_ff <= 1'b0;
      xact_ff <= 1'b0;
      second_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        tis_idle:
        begin
          if (start)
          begin
            stat_op_ff <= wb_dat_i[`TIS_CMD_STAT];
            xact_ff <= wb_dat_i[`TIS_CMD_XACT];
            we_ff <= wb_dat_i[`TIS_CMD_WE] & ~wb_dat_i[`TIS_CMD_STAT];
            addr_ff <= wb_dat_i[`TIS_CMD_STAT] ? `TIS_OFS_TX_STATUS : wb_dat_i[15:8];
            wdata_ff <= cmd_wdata;
            second_ff <= 1'b0;
            final_ff <= `TIS_BYTE_ZERO;
            req_ff <= 1'b1;
            state_ff <= tis_wait;
          end
        end
        tis_wait:
        begin
          if (link.ack)
          begin
            req_ff <= 1'b0;
            rdata_ff <= link.rdata;
            final_ff <= final_ff | link.rdata;
            if (need_second)
            begin
              second_ff <= 1'b1;
            end
            state_ff <= tis_gap;
          end
        end
        tis_gap:
        begin
          if (second_ff && !req_ff && final_ff[`TIS_BIT_DONE] && rdata_ff == final_ff
              && !final_ff[`TIS_BIT_FAIL] && stat_op_ff)
          begin
            req_ff <= 1'b1;
            final_ff[`TIS_BIT_DONE] <= 1'b1;
            state_ff <= tis_wait;
            rdata_ff <= `TIS_BYTE_ZERO;
          end
          else
          begin
            state_ff <= tis_idle;
          end
        end
        default:
        begin
          state_ff <= tis_idle;
        end
      endcase
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign link.req = req_ff;
  assign link.we = we_ff;
  assign link.addr = addr_ff;
  assign link.wdata = wdata_ff;

endmodule

/* testbench/tis_link_chk.sv */
`timescale 1ns/100ps
`include "tis_consts.svh"

module tis_link_chk
  import tis_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic req,
  input wire logic we,
  input wire tis_byte_type addr,
  input wire tis_byte_type wdata,
  input wire tis_byte_type rdata,
  input wire logic ack,
  input wire logic irq
);
  // ****************************************
  // link handshake and status read checks
  // ****************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  logic stat_rd;
  // addr is still held while ack is high, so it qualifies the answer
  assign stat_rd = ack && !we && (addr == `TIS_OFS_TX_STATUS);

  a_ack_one_pulse: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  a_ack_next_cycle: assert property (req && !ack |=> ack)
    else $error("link ack not one cycle after request");
  a_ack_has_req: assert property (ack |-> $past(req))
    else $error("link ack without request");
  a_req_held_steady: assert property (req && !ack |=>
    req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link request changed before ack");
  a_req_drops_after: assert property (ack |=> !req)
    else $error("link request not dropped after ack");
  a_rdata_holds: assert property (!(req && !we && !ack) |=> $stable(rdata))
    else $error("link read data changed without read");
  a_fill_flags_nest: assert property (stat_rd |->
    (!rdata[`TIS_BIT_EMPTY] || rdata[`TIS_BIT_HALF]) &&
    (!rdata[`TIS_BIT_HALF] || rdata[`TIS_BIT_NOT_FULL]))
    else $error("fill flags inconsistent");
  a_no_reread_fail: assert property (stat_rd && rdata[`TIS_BIT_DONE] &&
    rdata[`TIS_BIT_FAIL] |=> !req [*3])
    else $error("status reread after done with fail");

  c_done_read: cover property (stat_rd && rdata[`TIS_BIT_DONE]);
  c_buferr_read: cover property (stat_rd && rdata[`TIS_BIT_BUFERR]);
  c_buffer_write: cover property (ack && we && addr == `TIS_OFS_TX_BUFFER);
  c_irq_high: cover property ($rose(irq));
endmodule

/* testbench/testbench.sv */
`timescale 1ns/100ps
`include "tis_consts.svh"

module testbench
  import tis_pkg::*;
;
  logic clock_i;
  logic resetn_i;
  logic cyc, we, ack, osc, bat, xm, pend, strobe, pm, go;
  logic [3:0] adr, ev;
  logic [31:0] wdat, rdat, q;
  logic [8:0] pop;
  tis_byte_type txd;
  tis_byte_type bytes [0:16];
  int n_errors, samples_checked, i, k;
  integer seed;

  tis_link_if link();
  // stb follows cyc: classic single cycle only
  tis_host_end i_tis_host_end
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(cyc),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'hF),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .link(link)
  );
  tis_device_end i_tis_device_end
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .link(link),
    .osc_settled_i(osc),
    .battery_below_i(bat),
    .xact_mode_i(xm),
    .tx_byte_req_i(ev[0]),
    .bytes_pending_i(pend),
    .crc_sent_i(ev[1]),
    .xact_done_i(ev[2]),
    .ack_timeout_i(ev[3]),
    .tx_data_o(txd),
    .tx_data_strobe_o(strobe),
    .tx_go_o(go),
    .power_manager_en_o(pm)
  );
  tis_link_chk i_tis_link_chk
  (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .req(link.req),
    .we(link.we),
    .addr(link.addr),
    .wdata(link.wdata),
    .rdata(link.rdata),
    .ack(link.ack),
    .irq(link.irq)
  );

  // ****************************************
  // clock, watchdog and bus tasks
  // ****************************************
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial
  begin
    #300000;
    n_errors++;
    give_verdict();
  end

  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // values read right after an edge are the ones sampled at it
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge clock_i);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic op(input logic w, input tis_byte_type a, input tis_byte_type d,
    input logic s, input logic x);
    wb(1'b1, `TIS_WB_CMD, {13'h0000, x, s, w, a, d});
    do
      wb(1'b0, `TIS_WB_RESULT, `TIS_WORD_ZERO);
    while (q[`TIS_RES_BUSY] !== 1'b0);
  endtask

  task automatic wr(input tis_byte_type a, input tis_byte_type d);
    op(1'b1, a, d, 1'b0, 1'b0);
  endtask

  task automatic stat(input logic x);
    op(1'b0, `TIS_OFS_TX_STATUS, 8'h00, 1'b1, x);
  endtask

  task automatic irq_is(input logic v);
    wb(1'b0, `TIS_WB_RESULT, `TIS_WORD_ZERO);
    chk(q[`TIS_RES_IRQ], v);
  endtask

  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clock_i);
    ev <= 4'h0;
    @(posedge clock_i);
    pop = {strobe, txd};
    @(posedge clock_i);
  endtask

  function automatic tis_byte_type fill(input int n);
    return {2'b00, n <= 15, n <= 8, n == 0, 3'b000};
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    seed = 10;
    resetn_i = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = `TIS_WORD_ZERO;
    {osc, bat, xm, pend} = 4'h0;
    ev = 4'h0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    stat(1'b0);
    chk(q[15:8], fill(0));
    chk(q[`TIS_RES_IRQ], 1'b0);
    wb(1'b0, 4'h8, `TIS_WORD_ZERO);
    chk(q, `TIS_WORD_ZERO);
    for (i = 0; i < 17; i++)
    begin
      bytes[i] = 8'($random(seed));
      wr(`TIS_OFS_TX_BUFFER, bytes[i]);
      stat(1'b0);
      chk(q[15:8], fill(i < 16 ? i + 1 : 16) | (i < 16 ? 8'h00 : 8'h04));
    end
    stat(1'b0);
    chk(q[15:8], fill(16) | 8'h04);
    wr(`TIS_OFS_TX_CTRL, 8'h04);
    irq_is(1'b1);
    wr(`TIS_OFS_TX_CTRL, 8'h00);
    irq_is(1'b0);
    k = 1 + ($random(seed) & 7);
    for (i = 0; i < k; i++)
    begin
      pulse(4'h1);
      chk(pop, {1'b1, bytes[i]});
    end
    stat(1'b0);
    chk(q[15:8], fill(16 - k) | 8'h04);
    wr(`TIS_OFS_TX_CTRL, 8'h40);
    stat(1'b0);
    chk(q[15:8], fill(0));
    wr(`TIS_OFS_TX_BUFFER, 8'hA5);
    wr(`TIS_OFS_TX_CTRL, 8'h00);
    stat(1'b0);
    chk(q[15:8], fill(1));
    pulse(4'h1);
    chk(pop, 9'h1A5);
    pulse(4'h1);
    stat(1'b0);
    chk(q[15:8], fill(0));
    pend <= 1'b1;
    pulse(4'h1);
    stat(1'b0);
    chk(q[15:8], fill(0) | 8'h04);
    pend <= 1'b0;
    wr(`TIS_OFS_TX_CTRL, 8'hC2);
    chk(go, 1'b1);
    op(1'b0, `TIS_OFS_TX_CTRL, 8'h00, 1'b0, 1'b0);
    chk(q[7:0], 8'h83);
    pulse(4'hA);
    chk(go, 1'b0);
    irq_is(1'b1);
    stat(1'b0);
    chk(q[15:8], fill(0) | 8'h02);
    stat(1'b0);
    chk(q[15:8], fill(0));
    xm <= 1'b1;
    pulse(4'h2);
    stat(1'b1);
    chk(q[15:8], fill(0));
    pulse(4'h4);
    stat(1'b1);
    chk(q[15:8], fill(0) | 8'h02);
    chk(q[`TIS_RES_SECOND], 1'b1);
    pulse(4'hC);
    stat(1'b1);
    chk(q[15:8], fill(0) | 8'h03);
    chk(q[`TIS_RES_SECOND], 1'b0);
    osc <= 1'b1;
    bat <= 1'b1;
    repeat (4) @(posedge clock_i);
    stat(1'b0);
    chk(q[15:8], fill(0) | 8'h80);
    wr(`TIS_OFS_POWER_CTRL, 8'h82);
    chk(pm, 1'b1);
    op(1'b0, `TIS_OFS_POWER_CTRL, 8'h00, 1'b0, 1'b0);
    chk(q[7:0], 8'h82);
    stat(1'b0);
    chk(q[15:8], fill(0) | 8'hC0);
    irq_is(1'b1);
    bat <= 1'b0;
    repeat (4) @(posedge clock_i);
    stat(1'b0);
    chk(q[15:8], fill(0) | 8'h80);
    give_verdict();
  end
endmodule
